// File: hdl/trng_top.sv
`timescale 1ns/1ps
module trng_top
    import trng_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC, // start-up delay in cycles
    parameter int RAW_CYCLES = RAW_BIT_CYC, // cycles per raw bit
    parameter int BC_CYCLES = BC_PAIR_CYC // cycles per corrected pair bit
) (
    input wire logic ref_clk, // 125 MHz clock
    input wire logic rstn, // sync reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic noiseBit, // raw noise bit, async
    input wire logic noiseValid, // noise bit strobe, async
    output logic irq // interrupt level
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    trng_bus_s bus;
    logic access;
    logic wrStart, wrStop, wrEvent, wrShorts, wrSet, wrClr, wrCfg;
    logic mapped;
    assign access = psel && penable;
    assign bus.addr = paddr[11:0];
    assign bus.wr = access && pwrite;
    assign bus.rd = access && !pwrite;
    assign bus.wdata = pwdata;
    assign mapped = (paddr[31:12] == 20'h00000) && (bus.addr == OFS_START
        || bus.addr == OFS_STOP || bus.addr == OFS_EVENT || bus.addr == OFS_EVENT_TASK_SHORTCUTS
        || bus.addr == OFS_INTSET || bus.addr == OFS_INTCLR
        || bus.addr == OFS_CONFIG || bus.addr == OFS_VALUE);
    assign wrStart = bus.wr && bus.addr == OFS_START && bus.wdata[BIT_FLAG];
    assign wrStop = bus.wr && bus.addr == OFS_STOP && bus.wdata[BIT_FLAG];
    assign wrEvent = bus.wr && bus.addr == OFS_EVENT;
    assign wrShorts = bus.wr && bus.addr == OFS_EVENT_TASK_SHORTCUTS;
    assign wrSet = bus.wr && bus.addr == OFS_INTSET && bus.wdata[BIT_FLAG];
    assign wrClr = bus.wr && bus.addr == OFS_INTCLR && bus.wdata[BIT_FLAG];
    assign wrCfg = bus.wr && bus.addr == OFS_CONFIG;

    ////////////////////////////////////////////////////////////////////////
    // noise input synchroniser
    logic [1:0] bitSync_q, vldSync_q;
    logic vldOld_q;
    logic noiseStrobe;
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            bitSync_q <= 2'b00;
            vldSync_q <= 2'b00;
            vldOld_q <= 1'b0;
        end
        else
        begin
            bitSync_q <= {bitSync_q[0], noiseBit};
            vldSync_q <= {vldSync_q[0], noiseValid};
            vldOld_q <= vldSync_q[1];
        end
    end
    assign noiseStrobe = vldSync_q[1] && !vldOld_q;

    ////////////////////////////////////////////////////////////////////////
    // registers
    trng_state_e state_q, state_d;
    logic flag_q, short_q, ien_q, bcEn_q, irq_q;
    logic [7:0] value_q, shift_q;
    logic [2:0] bitCnt_q;
    logic [31:0] timer_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic pairHave_q, pairFirst_q;
    logic byteDone;
    logic stopNow;

    // raw pacing: a bit is taken when the timer expires and a noise strobe comes
    logic paceDone;
    logic [31:0] paceLimit;
    assign paceLimit = bcEn_q ? BC_CYCLES : RAW_CYCLES;
    assign paceDone = timer_q >= paceLimit - 1;

    // bias correction: von neumann pairs, 01 -> 0, 10 -> 1, equal pairs dropped
    logic rawTake, outBit, outValid;
    assign rawTake = (state_q == ST_RUN) && paceDone && noiseStrobe;
    assign outValid = rawTake && (!bcEn_q || (pairHave_q && pairFirst_q != bitSync_q[1]));
    assign outBit = bcEn_q ? pairFirst_q : bitSync_q[1];
    assign byteDone = outValid && bitCnt_q == 3'd7;
    assign stopNow = wrStop || (byteDone && short_q);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
                if (wrStart)
                    state_d = ST_WARM;
            ST_WARM:
                if (stopNow)
                    state_d = ST_IDLE;
                else if (timer_q >= STARTUP_CYCLES - 1)
                    state_d = ST_RUN;
            ST_RUN:
                if (stopNow)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state_q <= ST_IDLE;
            timer_q <= 32'h00000000;
        end
        else
        begin
            state_q <= state_d;
            if (state_q != state_d || rawTake || state_q == ST_IDLE)
                timer_q <= 32'h00000000;
            else if (!(state_q == ST_RUN && paceDone))
                timer_q <= timer_q + 32'h00000001;
        end
    end

    // byte assembly
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            shift_q <= RST_BYTE;
            bitCnt_q <= 3'd0;
            value_q <= RST_BYTE;
            pairHave_q <= 1'b0;
            pairFirst_q <= 1'b0;
        end
        else if (state_q != ST_RUN || stopNow)
        begin
            shift_q <= RST_BYTE;
            bitCnt_q <= 3'd0;
            pairHave_q <= 1'b0;
            if (byteDone)
                value_q <= {shift_q[6:0], outBit};
        end
        else
        begin
            if (rawTake)
            begin
                pairHave_q <= bcEn_q ? !pairHave_q : 1'b0;
                pairFirst_q <= bitSync_q[1];
            end
            if (outValid)
            begin
                shift_q <= {shift_q[6:0], outBit};
                bitCnt_q <= bitCnt_q + 3'd1;
            end
            if (byteDone)
                value_q <= {shift_q[6:0], outBit};
        end
    end

    // control and event registers
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            flag_q <= RST_BIT;
            short_q <= RST_BIT;
            ien_q <= RST_BIT;
            bcEn_q <= RST_BIT;
            irq_q <= 1'b0;
        end
        else
        begin
            if (byteDone)
                flag_q <= 1'b1;
            else if (wrEvent)
                flag_q <= bus.wdata[BIT_FLAG];
            if (wrShorts)
                short_q <= bus.wdata[BIT_FLAG];
            if (wrSet)
                ien_q <= 1'b1;
            else if (wrClr)
                ien_q <= 1'b0;
            if (wrCfg)
                bcEn_q <= bus.wdata[BIT_FLAG];
            irq_q <= flag_q && ien_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux and apb answer, no wait states
    logic [31:0] rdMux;
    assign rdMux = (bus.addr == OFS_EVENT) ? {31'h0, flag_q} :
        (bus.addr == OFS_EVENT_TASK_SHORTCUTS) ? {31'h0, short_q} :
        (bus.addr == OFS_INTSET || bus.addr == OFS_INTCLR) ? {31'h0, ien_q} :
        (bus.addr == OFS_CONFIG) ? {31'h0, bcEn_q} :
        (bus.addr == OFS_VALUE) ? {24'h0, value_q} : 32'h00000000;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            prdata_q <= (psel && !penable && !pwrite) ? rdMux : 32'h00000000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_flag_on_byte: assert property (@(posedge ref_clk) disable iff (!rstn)
        byteDone |=> flag_q)
        else $error("ready flag not set after byte");

    a_value_loads: assert property (@(posedge ref_clk) disable iff (!rstn)
        byteDone |=> value_q == $past({shift_q[6:0], outBit}))
        else $error("value not loaded");

    a_value_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
        !byteDone |=> $stable(value_q))
        else $error("value changed without byte");

    a_short_stops: assert property (@(posedge ref_clk) disable iff (!rstn)
        byteDone && short_q |=> state_q == ST_IDLE)
        else $error("shortcut ignored");

    a_stop_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrStop |=> state_q == ST_IDLE)
        else $error("stop ignored");

    a_irq_level: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq_q == $past(flag_q && ien_q))
        else $error("irq mismatch");

    a_ien_set_clr: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wrSet |=> ien_q) and (wrClr && !wrSet |=> !ien_q))
        else $error("irq enable mismatch");

    a_warm_delay: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == ST_WARM && timer_q < STARTUP_CYCLES - 1 && !stopNow |=> state_q == ST_WARM)
        else $error("start-up delay cut short");

    a_cfg_bit: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrCfg |=> bcEn_q == $past(bus.wdata[BIT_FLAG]))
        else $error("config bit");

    a_no_bits_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q != ST_RUN |-> !outValid)
        else $error("bits while stopped");

    a_start_warms: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == ST_IDLE && wrStart |=> state_q == ST_WARM)
        else $error("start ignored");

    a_idle_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == ST_IDLE && !wrStart |=> state_q == ST_IDLE)
        else $error("left idle without start");

    a_state_onehot: assert property (@(posedge ref_clk) disable iff (!rstn)
        $onehot(state_q))
        else $error("state code not one-hot");

    a_warm_to_run: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == ST_WARM && timer_q >= STARTUP_CYCLES - 1 && !stopNow |=> state_q == ST_RUN)
        else $error("start-up delay overrun");

    a_warm_no_bits: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == ST_WARM |-> !rawTake)
        else $error("bit taken during start-up");

    a_run_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == ST_RUN && !stopNow |=> state_q == ST_RUN)
        else $error("generation stopped on its own");

    a_partial_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == ST_RUN && stopNow |=> bitCnt_q == 3'd0 && shift_q == RST_BYTE)
        else $error("partial byte kept after stop");

    a_value_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q != ST_RUN |=> $stable(value_q))
        else $error("value changed while stopped");

    a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrEvent && !bus.wdata[BIT_FLAG] && !byteDone |=> !flag_q)
        else $error("ready flag not cleared");

    a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
        byteDone && wrEvent |=> flag_q)
        else $error("clear beat a new byte");

    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
        flag_q && !wrEvent |=> flag_q)
        else $error("ready flag dropped");

    a_flag_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
        !flag_q && !byteDone && !(wrEvent && bus.wdata[BIT_FLAG]) |=> !flag_q)
        else $error("ready flag without byte");

    a_short_reg: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrShorts |=> short_q == $past(bus.wdata[BIT_FLAG]))
        else $error("shortcut bit");

    a_short_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        byteDone && !short_q && !wrStop |=> state_q == ST_RUN)
        else $error("stopped without shortcut");

    a_ien_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !wrSet && !wrClr |=> $stable(ien_q))
        else $error("irq enable changed unasked");

    a_irq_on: assert property (@(posedge ref_clk) disable iff (!rstn)
        flag_q && ien_q |=> irq_q)
        else $error("irq missing");

    a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rstn)
        !ien_q |=> !irq_q)
        else $error("irq while disabled");

    a_cfg_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !wrCfg |=> $stable(bcEn_q))
        else $error("config changed unasked");

    a_bit_count: assert property (@(posedge ref_clk) disable iff (!rstn)
        outValid && !stopNow |=> bitCnt_q == $past(bitCnt_q) + 3'd1)
        else $error("bit count");

    a_shift_in: assert property (@(posedge ref_clk) disable iff (!rstn)
        outValid && !stopNow |=> shift_q == $past({shift_q[6:0], outBit}))
        else $error("holding register shift");

    a_bc_drop_equal: assert property (@(posedge ref_clk) disable iff (!rstn)
        rawTake && bcEn_q && pairHave_q && pairFirst_q == bitSync_q[1] |-> !outValid)
        else $error("equal pair not dropped");

    a_pace_wait: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == ST_RUN && timer_q < paceLimit - 1 |-> !outValid)
        else $error("bit taken before pace");

    a_timer_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        rawTake |=> timer_q == 32'h00000000)
        else $error("pace timer not restarted");

    a_value_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        psel && !penable && !pwrite && bus.addr == OFS_VALUE |=> prdata_q == {24'h0, $past(value_q)})
        else $error("value read data");

    a_event_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        psel && !penable && !pwrite && bus.addr == OFS_EVENT |=> prdata_q == {31'h0, $past(flag_q)})
        else $error("event read data");

endmodule

// File: hdl/trng_pkg.sv
// Notes on behaviour
// - start task at 0x000 begins generation, stop task at 0x004 ends it.
// - while running, bytes are produced continuously with no seed needed.
// - each completed byte is placed in the output register at 0x508.
// - value-ready event raised exactly once per byte written.
// - next byte overwrites output; software must read before next event.
// - bias correction removes tendency toward ones or zeros.
// - bits shift into an eight-bit holding register, presented in parallel.
// - config bit 0 at 0x504 enables bias correction, resets to 0.
// - bias correction slows production but gives uniform values.
// - byte interval is variable, never assumed constant.
// - event register 0x100 bit 0 is value-ready flag, resets 0.
// - shortcut bit 0 at 0x200 makes each ready event trigger stop.
// - writing 1 to 0x308 bit 0 clears irq enable; read shows enable.
// - start-up delay of typically 128 us after each start.
// - without correction a byte takes about 30 us typically.
// - with correction a byte takes about 120 us, no upper bound.
package trng_pkg;
    localparam logic [11:0] OFS_START = 12'h000;
    localparam logic [11:0] OFS_STOP = 12'h004;
    localparam logic [11:0] OFS_EVENT = 12'h100;
    localparam logic [11:0] OFS_EVENT_TASK_SHORTCUTS = 12'h200;
    localparam logic [11:0] OFS_INTSET = 12'h304;
    localparam logic [11:0] OFS_INTCLR = 12'h308;
    localparam logic [11:0] OFS_CONFIG = 12'h504;
    localparam logic [11:0] OFS_VALUE = 12'h508;
    localparam int BIT_FLAG = 0;
    localparam logic RST_BIT = 1'b0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int CLK_MHZ = 125;
    localparam int STARTUP_US = 128;
    localparam int RAW_US = 30;
    localparam int BC_US = 120;
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
    // pace per raw bit, eight bits to a byte
    localparam int RAW_BIT_CYC = RAW_US * CLK_MHZ / 8;
    // correction consumes about four raw bits per output bit
    localparam int BC_PAIR_CYC = BC_US * CLK_MHZ / 32;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WARM = 3'b010,
        ST_RUN = 3'b100
    } trng_state_e;

    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } trng_bus_s;
endpackage

// File: tb/trng_testbench.sv
`timescale 1ns/1ps
module testbench
    import trng_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic [31:0] pwdata = 32'h00000000;
    logic noiseBit = 1'b0;
    logic noiseValid = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int num_errors = 0;
    int check_count = 0;
    int rnd;
    logic [32:0] expQ[$];
    logic [7:0] byteA;
    logic [7:0] byteB;

    always #4 ref_clk = ~ref_clk;

    trng_top #(.STARTUP_CYCLES(20), .RAW_CYCLES(4), .BC_CYCLES(4)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .noiseBit(noiseBit), .noiseValid(noiseValid), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task results();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; reads leave their expected word in the queue
    task apb(input logic wr, input logic [11:0] adr, input logic [31:0] dat, input logic [32:0] e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {20'h00000, adr};
        pwdata <= dat;
        if (!wr)
            expQ.push_back(e);
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge ref_clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            chk("pready", 33'h1, 33'h0);
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] adr, input logic [31:0] dat);
        apb(1'b1, adr, dat, 33'h0);
    endtask

    task rd(input logic [11:0] adr, input logic [31:0] e);
        apb(1'b0, adr, 32'h00000000, {1'b0, e});
    endtask

    // compare each read answer with the oldest note
    always @(posedge ref_clk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            if (expQ.size() == 0)
                chk("read queue", 33'h1, 33'h0);
            else
                chk("prdata", expQ.pop_front(), {pslverr, prdata});
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task sendBit(input logic b);
        noiseBit <= b;
        repeat (3) @(posedge ref_clk);
        noiseValid <= 1'b1;
        repeat (6) @(posedge ref_clk);
        noiseValid <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    // corrected mode: a discarded 00 pair, then 10 for one and 01 for zero
    task sendByte(input logic [7:0] v, input logic bc, input int nb);
        if (bc)
        begin
            sendBit(1'b0);
            sendBit(1'b0);
        end
        for (int i = 7; i > 7 - nb; i--)
        begin
            sendBit(bc ? v[i] : v[i]);
            if (bc)
                sendBit(!v[i]);
        end
    endtask

    task waitIrq();
        int n;
        for (n = 0; n < 200 && irq !== 1'b1; n++)
            @(posedge ref_clk);
        chk("irq", 33'h1, {32'h0, irq});
        if (irq !== 1'b1)
            results();
    endtask

    task clearFlag();
        wr(OFS_EVENT, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("irq", 33'h0, {32'h0, irq});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rnd = $urandom(32'hca44c233);
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(OFS_EVENT, 32'h0);
        rd(OFS_EVENT_TASK_SHORTCUTS, 32'h0);
        rd(OFS_INTCLR, 32'h0);
        rd(OFS_CONFIG, 32'h0);
        rd(OFS_VALUE, 32'h0);
        apb(1'b0, 12'h800, 32'h0, {1'b1, 32'h0});
        wr(OFS_INTSET, 32'h1);
        rd(OFS_INTCLR, 32'h1);
        wr(OFS_CONFIG, 32'h1);
        rd(OFS_CONFIG, 32'h1);
        wr(OFS_CONFIG, 32'h0);
        wr(OFS_START, 32'h1);
        sendBit(1'b1);
        repeat (30) @(posedge ref_clk);
        byteA = 8'($urandom);
        sendByte(byteA, 1'b0, 8);
        waitIrq();
        rd(OFS_VALUE, {24'h0, byteA});
        rd(OFS_EVENT, 32'h1);
        clearFlag();
        byteA = 8'($urandom);
        byteB = 8'($urandom);
        sendByte(byteA, 1'b0, 8);
        sendByte(byteB, 1'b0, 8);
        rd(OFS_VALUE, {24'h0, byteB});
        wr(OFS_INTCLR, 32'h1);
        rd(OFS_INTSET, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("irq", 33'h0, {32'h0, irq});
        wr(OFS_INTSET, 32'h1);
        waitIrq();
        clearFlag();
        wr(OFS_CONFIG, 32'h1);
        byteA = 8'($urandom);
        sendByte(byteA, 1'b1, 8);
        waitIrq();
        rd(OFS_VALUE, {24'h0, byteA});
        clearFlag();
        wr(OFS_CONFIG, 32'h0);
        sendByte(8'hff, 1'b0, 4);
        wr(OFS_STOP, 32'h1);
        wr(OFS_START, 32'h1);
        repeat (40) @(posedge ref_clk);
        byteB = 8'($urandom);
        sendByte(byteB, 1'b0, 8);
        waitIrq();
        rd(OFS_VALUE, {24'h0, byteB});
        clearFlag();
        wr(OFS_STOP, 32'h1);
        sendByte(~byteB, 1'b0, 8);
        repeat (10) @(posedge ref_clk);
        rd(OFS_VALUE, {24'h0, byteB});
        wr(OFS_EVENT_TASK_SHORTCUTS, 32'h1);
        wr(OFS_START, 32'h1);
        repeat (40) @(posedge ref_clk);
        sendByte(byteA, 1'b0, 8);
        waitIrq();
        clearFlag();
        sendByte(~byteA, 1'b0, 8);
        repeat (10) @(posedge ref_clk);
        rd(OFS_VALUE, {24'h0, byteA});
        rd(OFS_EVENT, 32'h0);
        results();
    end
endmodule
